// ---- dv/bwhmp_monitor.sv ----
/*
 * pin-level checker for the byte-wide host message port.
 * assumes one clock domain and the carrier's signals wired in by name.
 */
module bwhmp_monitor
    import bwhmp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic reset_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_sel;

    assign rd_sel = !chip_select_n && !read_n && reset_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////////
    a_cs_gates_bus: assert property (chip_select_n |=> !dev_data_oe)
        else $error("device drove bus while not selected");
    a_read_drives_bus: assert property (rd_sel |=> dev_data_oe)
        else $error("device did not drive bus on read");
    a_oe_has_cause: assert property (dev_data_oe |-> $past(rd_sel))
        else $error("device drove bus without a read");
    a_reset_quiet_bus: assert property (!reset_n |=> !dev_data_oe)
        else $error("device drove bus while held in reset");
    a_write_strobe_len: assert property ($fell(write_n) |-> !write_n [*5] ##1 write_n)
        else $error("write strobe length wrong");
    a_read_strobe_len: assert property ($fell(read_n) |-> !read_n [*5] ##1 read_n)
        else $error("read strobe length wrong");
    a_write_selected: assert property (!write_n |-> !chip_select_n && host_data_oe && read_n)
        else $error("write strobe without select or data");
    a_write_data_hold: assert property (!write_n ##1 !write_n |->
        $stable(host_data_out) && $stable(addr))
        else $error("write data or address moved in strobe");
    a_read_host_off: assert property (!read_n |-> !host_data_oe && !chip_select_n)
        else $error("host drove bus during read");
endmodule : bwhmp_monitor

// ---- dv/tb.sv ----
/*
 * self-checking bench: host end and device end joined by the pin carrier.
 * assumes the avalon side is the only way software reaches the port.
 */
module tb
    import bwhmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, dsp_msg_pending, dsp_out_ready;
    logic dsp_msg_write = 1'b0;
    logic dsp_msg_read = 1'b0;
    logic dsp_unsolicited = 1'b0;
    logic pcm_af = 1'b0;
    logic cmp_af = 1'b0;
    logic [7:0] dsp_msg_wdata = 8'h00;
    logic [7:0] dsp_msg_rdata, pcm_byte, compressed_byte;
    logic pcm_byte_valid, pcm_rst, compressed_byte_valid, cmp_rst;
    logic [7:0] pcm_last = 8'h00;
    logic [7:0] cmp_last = 8'h00;
    int err_total = 0;
    int checks = 0;
    int stream_cnt = 0;

    bwhmp_if bus ();
    // pull-up: a released bus reads all ones
    assign bus.data_in = bus.host_data_oe ? bus.host_data_out
        : (bus.dev_data_oe ? bus.dev_data_out : 8'hff);

    bwhmp_host u_bwhmp_host (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .pins(bus));
    bwhmp_device u_bwhmp_device (.clk(clk), .srst(srst), .pins(bus),
        .dsp_msg_write(dsp_msg_write), .dsp_msg_wdata(dsp_msg_wdata),
        .dsp_msg_read(dsp_msg_read), .dsp_msg_rdata(dsp_msg_rdata),
        .dsp_msg_pending(dsp_msg_pending), .dsp_out_ready(dsp_out_ready),
        .dsp_unsolicited(dsp_unsolicited), .pcm_byte(pcm_byte), .pcm_byte_valid(pcm_byte_valid),
        .pcm_channel_reset(pcm_rst), .pcm_buffer_almost_full(pcm_af),
        .compressed_byte(compressed_byte), .compressed_byte_valid(compressed_byte_valid),
        .compressed_channel_reset(cmp_rst), .compressed_buffer_almost_full(cmp_af));
    bwhmp_monitor u_bwhmp_monitor (.clk(clk), .srst(srst), .chip_select_n(bus.chip_select_n),
        .read_n(bus.read_n), .write_n(bus.write_n), .addr(bus.addr),
        .host_data_out(bus.host_data_out), .host_data_oe(bus.host_data_oe),
        .dev_data_oe(bus.dev_data_oe), .reset_n(bus.reset_n));

    initial begin
        forever #4 clk = ~clk;
    end

    // sampled off the active edge so pulses are never missed by a race
    always @(negedge clk) begin
        if (pcm_byte_valid === 1'b1) begin
            stream_cnt++;
            pcm_last = pcm_byte;
        end
        if (compressed_byte_valid === 1'b1) begin
            stream_cnt++;
            cmp_last = compressed_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clk);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task av(input logic r, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        logic w;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= r;
        avs_write <= !r;
        w = 1'b1;
        q = READ_UNMAPPED;
        // read just before the edge they stand at; only the watchdog ends a wait
        while (w !== 1'b0) begin
            @(negedge clk);
            w = avs_waitrequest;
            q = avs_readdata;
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // callers look at outputs once they have settled
        @(negedge clk);
    endtask : av

    task wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b0, a, d, q);
    endtask : wr

    task pin(input logic r, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] s;
        int n;
        wr(CR_WDATA, {24'h0, d});
        wr(CR_COMMAND, {29'h0, r, a});
        s = 32'h8;
        n = 0;
        while (s[3] !== 1'b0 && n < 64) begin
            av(1'b1, CR_COMMAND, 32'h0, s);
            n++;
        end
        chk32(s & 32'h8, 32'h0);
        av(1'b1, CR_RDATA, 32'h0, s);
        q = s[7:0];
    endtask : pin

    task dsp_pulse(input logic is_write, input logic [7:0] d);
        @(posedge clk);
        dsp_msg_write <= is_write;
        dsp_msg_read <= !is_write;
        dsp_msg_wdata <= d;
        @(posedge clk);
        dsp_msg_write <= 1'b0;
        dsp_msg_read <= 1'b0;
        @(negedge clk);
    endtask : dsp_pulse

    ////////////////////////////////////////////////////////////////////////////////
    task t_inbound;
        logic [7:0] q;
        pin(1'b0, ADDR_MESSAGE, 8'ha5, q);
        chk1(dsp_msg_pending, 1'b1);
        chk32({24'h0, dsp_msg_rdata}, 32'ha5);
        pin(1'b1, ADDR_CONTROL, 8'h00, q);
        chk32({24'h0, q & 8'h06}, 32'h4);
        dsp_pulse(1'b0, 8'h00);
        chk1(dsp_msg_pending, 1'b0);
        pin(1'b1, ADDR_CONTROL, 8'h00, q);
        chk32({24'h0, q & 8'h06}, 32'h0);
        $display("test inbound done");
    endtask : t_inbound

    task t_outbound;
        logic [7:0] q;
        logic [31:0] s;
        wr(CR_IRQ_STATUS, 32'h3);
        @(posedge clk);
        dsp_unsolicited <= 1'b1;
        dsp_pulse(1'b1, 8'h3c);
        chk1(dsp_out_ready, 1'b1);
        chk1(bus.interrupt_request_n, 1'b0);
        av(1'b1, CR_STATUS, 32'h0, s);
        chk32(s & 32'h1, 32'h1);
        chk1(irq, 1'b0);
        wr(CR_IRQ_MASK, 32'h2);
        chk1(irq, 1'b1);
        pin(1'b1, ADDR_CONTROL, 8'h00, q);
        chk32({24'h0, q & 8'h06}, 32'h2);
        pin(1'b1, ADDR_MESSAGE, 8'h00, q);
        chk32({24'h0, q}, 32'h3c);
        chk1(dsp_out_ready, 1'b0);
        chk1(bus.interrupt_request_n, 1'b1);
        av(1'b1, CR_IRQ_STATUS, 32'h0, s);
        chk32(s, 32'h3);
        @(posedge clk);
        dsp_unsolicited <= 1'b0;
        wr(CR_IRQ_STATUS, 32'h3);
        av(1'b1, CR_IRQ_STATUS, 32'h0, s);
        chk32(s, 32'h0);
        chk1(irq, 1'b0);
        $display("test outbound done");
    endtask : t_outbound

    // a held channel reset must swallow the byte
    task stream(input logic [1:0] a, input logic [7:0] rbit, input logic [7:0] d);
        logic [7:0] q;
        int c0;
        c0 = stream_cnt;
        pin(1'b0, a, d, q);
        chk32(32'(stream_cnt), 32'(c0 + 1));
        chk32({24'h0, (a == ADDR_PCM) ? pcm_last : cmp_last}, {24'h0, d});
        pin(1'b0, ADDR_CONTROL, rbit, q);
        chk1((a == ADDR_PCM) ? pcm_rst : cmp_rst, 1'b1);
        pin(1'b0, a, ~d, q);
        chk32(32'(stream_cnt), 32'(c0 + 1));
        pin(1'b0, ADDR_CONTROL, 8'h00, q);
        chk1((a == ADDR_PCM) ? pcm_rst : cmp_rst, 1'b0);
        $display("test stream done");
    endtask : stream

    task t_almost_full;
        logic [7:0] q;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            pcm_af <= (i == 0);
            cmp_af <= (i == 1);
            pin(1'b1, ADDR_CONTROL, 8'h00, q);
            chk32({24'h0, q & 8'h18}, (i == 0) ? 32'h10 : 32'h08);
        end
        $display("test almost full done");
    endtask : t_almost_full

    task t_dev_reset;
        logic [7:0] q;
        logic [31:0] s;
        wr(CR_STATUS, 32'h2);
        av(1'b1, CR_STATUS, 32'h0, s);
        chk32(s, 32'h2);
        pin(1'b0, ADDR_MESSAGE, 8'h77, q);
        chk1(dsp_msg_pending, 1'b0);
        chk32({24'h0, dsp_msg_rdata}, 32'ha5);
        pin(1'b1, ADDR_CONTROL, 8'h00, q);
        chk32({24'h0, q}, 32'hff);
        wr(CR_STATUS, 32'h0);
        pin(1'b1, ADDR_CONTROL, 8'h00, q);
        chk32({24'h0, q}, 32'h08);
        av(1'b1, 3'h7, 32'h0, s);
        chk32(s, READ_UNMAPPED);
        $display("test device reset done");
    endtask : t_dev_reset

    task wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #100000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_inbound();
        t_outbound();
        stream(ADDR_PCM, 8'h20, 8'h5a);
        stream(ADDR_COMPRESSED, 8'h40, 8'hc3);
        t_almost_full();
        t_dev_reset();
        wrap_up();
    end
endmodule : tb

// ---- rtl/bwhmp_device.sv ----
/*
 * decoder end of the byte-wide host message port: message pipe in both
 * directions, control/status register, pcm and compressed byte streams.
 * assumes host pins are synchronous to clk; the dsp side is a simple
 * strobe/data user port.
 */
module bwhmp_device
    import bwhmp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins
    bwhmp_if.device pins,
    // dsp message side
    input wire logic dsp_msg_write,
    input wire logic [7:0] dsp_msg_wdata,
    input wire logic dsp_msg_read,
    output logic [7:0] dsp_msg_rdata,
    output logic dsp_msg_pending,
    output logic dsp_out_ready,
    input wire logic dsp_unsolicited,
    // input streams
    output logic [7:0] pcm_byte,
    output logic pcm_byte_valid,
    output logic pcm_channel_reset,
    input wire logic pcm_buffer_almost_full,
    output logic [7:0] compressed_byte,
    output logic compressed_byte_valid,
    output logic compressed_channel_reset,
    input wire logic compressed_buffer_almost_full
);
    // one register copy of all port state
    typedef struct packed {
        logic [7:0] to_dsp;
        logic [7:0] to_host;
        logic in_busy;
        logic out_ready;
        logic pcm_rst;
        logic cmp_rst;
        logic wr_active;
        logic [1:0] wr_addr;
        logic [7:0] wr_data;
        logic rd_active;
        logic [1:0] rd_addr;
        logic [7:0] pcm_b;
        logic pcm_v;
        logic [7:0] cmp_b;
        logic cmp_v;
        logic [7:0] bus_out;
        logic bus_oe;
    } bwhmp_dev_t;

    bwhmp_dev_t st;
    bwhmp_dev_t next_st;
    logic live;
    logic wr_low;
    logic rd_low;
    logic wr_end;
    logic rd_end;
    logic [7:0] ctrl_view;
    logic [7:0] read_mux;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // pin decode: nothing counts while the port is held in reset
        live = pins.reset_n;
        wr_low = live && !pins.chip_select_n && !pins.write_n;
        rd_low = live && !pins.chip_select_n && !pins.read_n;
        // a cycle cut by reset is dropped, not committed
        wr_end = live && st.wr_active && !wr_low;
        rd_end = live && st.rd_active && !rd_low;

        // control view: write-only bits always read back as zero
        ctrl_view = BYTE_RESET;
        ctrl_view[BIT_OUT_READY] = st.out_ready;
        ctrl_view[BIT_IN_BUSY] = st.in_busy;
        ctrl_view[BIT_CMP_FULL] = compressed_buffer_almost_full;
        ctrl_view[BIT_PCM_FULL] = pcm_buffer_almost_full;

        case (pins.addr)
            ADDR_MESSAGE: begin
                read_mux = st.to_host;
            end
            ADDR_CONTROL: begin
                read_mux = ctrl_view;
            end
            ADDR_PCM: begin
                // stream registers are write only
                read_mux = BYTE_RESET;
            end
            ADDR_COMPRESSED: begin
                read_mux = BYTE_RESET;
            end
            default: begin
                read_mux = BYTE_RESET;
            end
        endcase

        next_st = st;
        next_st.pcm_v = 1'b0;
        next_st.cmp_v = 1'b0;

        // read: the bus is driven one cycle after select and strobe fall
        next_st.bus_oe = rd_low;
        next_st.bus_out = read_mux;
        next_st.rd_active = rd_low;
        if (rd_low) begin
            next_st.rd_addr = pins.addr;
        end

        // write: data sampled each cycle while low, committed on first rise
        next_st.wr_active = wr_low;
        if (wr_low) begin
            next_st.wr_addr = pins.addr;
            next_st.wr_data = pins.data_in;
        end

        // dsp side of the message pipe
        if (dsp_msg_read) begin
            next_st.in_busy = 1'b0;
        end
        if (dsp_msg_write) begin
            next_st.to_host = dsp_msg_wdata;
            next_st.out_ready = 1'b1;
        end
        // a dsp write in the same cycle keeps the flag set
        if (rd_end && st.rd_addr == ADDR_MESSAGE && !dsp_msg_write) begin
            next_st.out_ready = 1'b0;
        end

        // host write commit; it beats a same-cycle dsp read of the flag
        if (wr_end) begin
            case (st.wr_addr)
                ADDR_MESSAGE: begin
                    next_st.to_dsp = st.wr_data;
                    next_st.in_busy = 1'b1;
                end
                ADDR_CONTROL: begin
                    // reserved bits are dropped whatever the host sends
                    next_st.pcm_rst = st.wr_data[BIT_PCM_RST];
                    next_st.cmp_rst = st.wr_data[BIT_CMP_RST];
                end
                ADDR_PCM: begin
                    next_st.pcm_b = st.wr_data;
                    next_st.pcm_v = !st.pcm_rst;
                end
                ADDR_COMPRESSED: begin
                    next_st.cmp_b = st.wr_data;
                    next_st.cmp_v = !st.cmp_rst;
                end
                default: begin
                    next_st.cmp_v = 1'b0;
                end
            endcase
        end

        if (!live) begin
            next_st.bus_oe = 1'b0;
            next_st.wr_active = 1'b0;
            next_st.rd_active = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pins.dev_data_out = st.bus_out;
    assign pins.dev_data_oe = st.bus_oe;
    // level request while outgoing bytes wait and the dsp asks for it
    assign pins.interrupt_request_n = !(st.out_ready && dsp_unsolicited);

    // dsp user side
    assign dsp_msg_rdata = st.to_dsp;
    assign dsp_msg_pending = st.in_busy;
    assign dsp_out_ready = st.out_ready;

    // stream outputs
    assign pcm_byte = st.pcm_b;
    assign pcm_byte_valid = st.pcm_v;
    assign pcm_channel_reset = st.pcm_rst;
    assign compressed_byte = st.cmp_b;
    assign compressed_byte_valid = st.cmp_v;
    assign compressed_channel_reset = st.cmp_rst;
endmodule : bwhmp_device

// ---- rtl/bwhmp_host.sv ----
/*
 * host end: avalon-mm slave registers command one pin cycle at a time.
 * assumes the device samples pins on the same clk.
 */
module bwhmp_host
    import bwhmp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // pins
    bwhmp_if.host pins
);
    typedef struct packed {
        bwhmp_state_t fsm;
        logic [3:0] count;
        logic is_read;
        logic [1:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic dev_reset;
        logic [31:0] rd_out;
        logic ack;
    } bwhmp_host_t;

    bwhmp_host_t st;
    bwhmp_host_t next_st;
    logic busy;
    logic done_ev;
    logic req_ev;

    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        busy = st.fsm != BWH_IDLE;
        done_ev = 1'b0;
        req_ev = !pins.interrupt_request_n;
        if ((avs_read || avs_write) && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rd_out = READ_UNMAPPED;
            if (avs_read) begin
                case (avs_address)
                    CR_COMMAND: next_st.rd_out = {28'h0, busy, st.is_read, st.addr};
                    CR_WDATA: next_st.rd_out = {24'h0, st.wdata};
                    CR_RDATA: next_st.rd_out = {24'h0, st.rdata};
                    CR_STATUS: next_st.rd_out = {30'h0, st.dev_reset, req_ev};
                    CR_IRQ_STATUS: next_st.rd_out = {30'h0, st.irq_status};
                    CR_IRQ_MASK: next_st.rd_out = {30'h0, st.irq_mask};
                    default: next_st.rd_out = READ_UNMAPPED;
                endcase
            end else begin
                case (avs_address)
                    CR_COMMAND: begin
                        // a command while busy is dropped: poll busy first
                        if (!busy) begin
                            next_st.addr = avs_writedata[1:0];
                            next_st.is_read = avs_writedata[2];
                            next_st.fsm = BWH_SETUP;
                            next_st.count = SETUP_CYCLES;
                        end
                    end
                    CR_WDATA: next_st.wdata = avs_writedata[7:0];
                    CR_STATUS: next_st.dev_reset = avs_writedata[1];
                    CR_IRQ_STATUS: next_st.irq_status = st.irq_status & ~avs_writedata[1:0];
                    CR_IRQ_MASK: next_st.irq_mask = avs_writedata[1:0];
                    default: next_st.irq_mask = st.irq_mask;
                endcase
            end
        end
        case (st.fsm)
            BWH_IDLE: next_st.count = next_st.count;
            BWH_SETUP: begin
                next_st.count = st.count - 4'h1;
                if (st.count == 4'h1) begin
                    next_st.fsm = BWH_STROBE;
                    next_st.count = STROBE_CYCLES;
                end
            end
            BWH_STROBE: begin
                next_st.count = st.count - 4'h1;
                if (st.count == 4'h1) begin
                    next_st.fsm = BWH_HOLD;
                    if (st.is_read) begin
                        next_st.rdata = pins.data_in;
                    end
                end
            end
            BWH_HOLD: begin
                next_st.fsm = BWH_IDLE;
                done_ev = 1'b1;
            end
            default: next_st.fsm = BWH_IDLE;
        endcase
        // set wins over a same-cycle clear
        if (done_ev) begin
            next_st.irq_status[0] = 1'b1;
        end
        if (req_ev) begin
            next_st.irq_status[1] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
    assign avs_readdata = st.rd_out;
    assign irq = |(st.irq_status & st.irq_mask);
    assign pins.reset_n = !st.dev_reset;
    assign pins.addr = st.addr;
    assign pins.chip_select_n = !(st.fsm == BWH_STROBE);
    assign pins.read_n = !(st.fsm == BWH_STROBE && st.is_read);
    assign pins.write_n = !(st.fsm == BWH_STROBE && !st.is_read);
    assign pins.host_data_out = st.wdata;
    assign pins.host_data_oe = !st.is_read && st.fsm != BWH_IDLE;
endmodule : bwhmp_host

// ---- rtl/bwhmp_if.sv ----
/*
 * pin-level carrier between the host controller and the decoder port.
 * assumes the bench resolves the shared data bus from the two enables.
 */
interface bwhmp_if;
    logic chip_select_n;
    logic read_n;
    logic write_n;
    logic [1:0] addr;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic [7:0] data_in;
    logic interrupt_request_n;
    logic reset_n;
    modport host (output chip_select_n, output read_n, output write_n, output addr,
                  output host_data_out, output host_data_oe, input data_in,
                  input interrupt_request_n, output reset_n);
    modport device (input chip_select_n, input read_n, input write_n, input addr,
                    output dev_data_out, output dev_data_oe, input data_in,
                    output interrupt_request_n, input reset_n);
endinterface : bwhmp_if

// ---- rtl/bwhmp_pkg.sv ----
/*
 * constants and types shared by both ends of the byte-wide host message port.
 * assumes a single 125 mhz clock, synchronous active-high reset.
 */
package bwhmp_pkg;
    localparam logic [1:0] ADDR_MESSAGE = 2'h0;
    localparam logic [1:0] ADDR_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_PCM = 2'h2;
    localparam logic [1:0] ADDR_COMPRESSED = 2'h3;
    localparam int BIT_OUT_READY = 1;
    localparam int BIT_IN_BUSY = 2;
    localparam int BIT_CMP_FULL = 3;
    localparam int BIT_PCM_FULL = 4;
    localparam int BIT_PCM_RST = 5;
    localparam int BIT_CMP_RST = 6;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h60;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // controller registers on the avalon side (word addresses)
    localparam logic [2:0] CR_COMMAND = 3'h0;
    localparam logic [2:0] CR_WDATA = 3'h1;
    localparam logic [2:0] CR_RDATA = 3'h2;
    localparam logic [2:0] CR_STATUS = 3'h3;
    localparam logic [2:0] CR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] CR_IRQ_MASK = 3'h5;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
    // strobe timing in controller cycles
    localparam int STROBE_NS = 40;
    localparam int CLK_NS = 8;
    localparam logic [3:0] STROBE_CYCLES = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] SETUP_CYCLES = 4'h1;
    typedef enum logic [2:0] {
        BWH_IDLE = 3'b000,
        BWH_SETUP = 3'b001,
        BWH_STROBE = 3'b010,
        BWH_HOLD = 3'b011
    } bwhmp_state_t;
endpackage : bwhmp_pkg
